// ---- charge_ctrl_pkg.sv ----
// Constants and types for the charge status and precharge timer block
// How it works
// RULE_01 - Charging allowed only while pack temperature sits between cold and hot limits.
// RULE_02 - Temperature out of window: switch off immediately, hold timer counts.
// RULE_03 - Temperature back in window: resume charging from held timer counts.
// RULE_04 - Input-ok pulled low only with input present and no overvoltage.
// RULE_05 - Overvoltage flag switches the charger off into standby.
// RULE_06 - Overvoltage is not latched; normal operation returns when flag drops.
// RULE_07 - Status pins: precharge both on, fast first only, done second only.
// RULE_08 - Both status transistors off in suspend, fault, off, overvoltage, absent, short.
// RULE_09 - Termination disabled: never report done, show fast or precharge by voltage.
// RULE_10 - Fast current above low-voltage threshold, otherwise precharge current.
// RULE_11 - Precharge timer times out at factor times the fast-phase timeout.
// RULE_12 - Precharge timer reset in standby, above threshold, or program pin floating.
// RULE_13 - Precharge timer counts only charging, pin driven, below threshold.
// RULE_14 - Suspend below threshold freezes the precharge count, later resumed.
// RULE_15 - Timer expiry below threshold switches charger off and sets fault latch.
// RULE_16 - Fault latch enables recovery current while input present and below threshold.
// RULE_17 - Fault latch cleared by inhibit rising, overvoltage, input loss, timer disabled.
// RULE_18 - Without a temperature input, temperature counts as always in range.
// RULE_19 - Inhibit high keeps the device in standby; low enables charging.
// RULE_20 - All comparator and host inputs pass two flip-flops before use.
// RULE_21 - Status and input-ok outputs come straight from registers.
`default_nettype none
package charge_ctrl_pkg;
  // Precharge timer width and scaling
  localparam int TICK_W = 24;
  localparam int FACTOR_W = 4;
  localparam logic [FACTOR_W-1:0] PCHG_FACTOR_DEF = 4'h1;
  localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;
  localparam logic [TICK_W-1:0] TICK_ONE = 24'h000001;
  // Synchroniser depth
  localparam int SYNC_W = 2;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_CHARGING = 2'b01,
    MODE_SUSPEND = 2'b11
  } mode_t;

  // Raw analog comparator and host inputs
  typedef struct packed {
    logic inputPresent;
    logic inputOvervoltage;
    logic tempAboveCold;
    logic tempBelowHot;
    logic aboveLowVoltage;
    logic timerPinFloating;
    logic chargeInhibit;
    logic finishDetectInhibit;
    logic finishDetected;
    logic cellAbsent;
    logic outputShort;
  } sense_t;

  // Status pin drives (1 = transistor conducts)
  typedef struct packed {
    logic statusA;
    logic statusB;
    logic inputOk;
  } status_t;

  // Power path controls
  typedef struct packed {
    logic powerSwitchOn;
    logic fastCurrentSel;
    logic recoveryCurrentOn;
  } drive_t;
endpackage
`default_nettype wire

// ---- charge_status_and_precharge_timer.sv ----
// Mode control, status encoding and precharge safety timer of a linear charger
`timescale 1ns/1ns
`default_nettype none
module charge_status_and_precharge_timer #(
  parameter bit HAS_TEMP_SENSE = 1'b1,
  parameter bit HAS_FINISH_INHIBIT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire charge_ctrl_pkg::sense_t senseIn,
  input wire logic timerTick,
  input wire logic [charge_ctrl_pkg::TICK_W-1:0] fastPhaseTimeout,
  input wire logic [charge_ctrl_pkg::FACTOR_W-1:0] preconditionTimeFactor,
  output charge_ctrl_pkg::status_t statusOut,
  output charge_ctrl_pkg::drive_t driveOut,
  output logic prechargeFault,
  output charge_ctrl_pkg::mode_t modeOut
);
  import charge_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] rstSync_reg;
  logic rstnInt;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_reg <= '0;
    end else begin
      rstSync_reg <= {rstSync_reg[SYNC_W-2:0], 1'b1};
    end
  end
  assign rstnInt = rstSync_reg[SYNC_W-1];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  sense_t meta_reg, sense_reg;
  logic tick1_reg, tick_reg;
  logic inhibitPrev_reg;

  // Two flip-flops on every comparator and host input
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      meta_reg <= '0;
      sense_reg <= '0;
      tick1_reg <= 1'b0;
      tick_reg <= 1'b0;
      inhibitPrev_reg <= 1'b0;
    end else begin
      meta_reg <= senseIn; // see RULE_20
      sense_reg <= meta_reg;
      tick1_reg <= timerTick;
      tick_reg <= tick1_reg;
      inhibitPrev_reg <= sense_reg.chargeInhibit;
    end
  end

  // ----------------------------------------------------------------
  // Derived conditions
  // ----------------------------------------------------------------
  logic tempOk, inputGood, inhibitRise, finishEnabled;
  logic aboveLow, timerDisabled;

  // Qualification terms from synchronised inputs
  always_comb begin
    // Window check, forced good when the sense input is absent
    tempOk = HAS_TEMP_SENSE ? (sense_reg.tempAboveCold && sense_reg.tempBelowHot)
                            : 1'b1; // see RULE_01 see RULE_18
    inputGood = sense_reg.inputPresent && !sense_reg.inputOvervoltage;
    inhibitRise = sense_reg.chargeInhibit && !inhibitPrev_reg;
    aboveLow = sense_reg.aboveLowVoltage;
    timerDisabled = sense_reg.timerPinFloating;
    finishEnabled = !timerDisabled &&
                    !(HAS_FINISH_INHIBIT && sense_reg.finishDetectInhibit);
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  mode_t mode_reg, mode_next;
  logic fault_reg, fault_next;

  // Standby on inhibit, overvoltage or no input; suspend on bad temperature
  always_comb begin
    mode_next = mode_reg;
    if (!inputGood || sense_reg.chargeInhibit) begin
      mode_next = MODE_STANDBY; // see RULE_05 see RULE_06 see RULE_19
    end else begin
      unique case (mode_reg)
        MODE_STANDBY: begin
          mode_next = tempOk ? MODE_CHARGING : MODE_SUSPEND;
        end
        MODE_CHARGING: begin
          if (!tempOk) begin
            mode_next = MODE_SUSPEND; // see RULE_02
          end
        end
        MODE_SUSPEND: begin
          if (tempOk) begin
            mode_next = MODE_CHARGING; // see RULE_03
          end
        end
        default: begin
          mode_next = MODE_STANDBY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Precharge safety timer
  // ----------------------------------------------------------------
  logic [TICK_W+FACTOR_W-1:0] limit;
  logic [TICK_W+FACTOR_W-1:0] count_reg, count_next;
  logic timerReset, timerCount;

  // Reset, hold or count, and latch the fault on expiry
  always_comb begin
    limit = fastPhaseTimeout * preconditionTimeFactor; // see RULE_11
    timerReset = (mode_reg == MODE_STANDBY) || aboveLow || timerDisabled; // see RULE_12
    timerCount = (mode_reg == MODE_CHARGING) && !timerDisabled && !aboveLow &&
                 !fault_reg; // see RULE_13
    count_next = count_reg;
    if (timerReset) begin
      count_next = '0;
    end else if (timerCount && tick_reg) begin
      count_next = count_reg + 1'b1; // suspend leaves it frozen, see RULE_14
    end
    fault_next = fault_reg;
    if (inhibitRise || sense_reg.inputOvervoltage || !sense_reg.inputPresent ||
        timerDisabled) begin
      fault_next = 1'b0; // see RULE_17
    end else if (timerCount && !aboveLow && count_reg >= limit &&
                 limit != '0) begin
      fault_next = 1'b1; // see RULE_15
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  status_t status_next;
  drive_t drive_next;
  logic anyOff;

  // Status pin encoding and power path selection
  always_comb begin
    status_next = '0;
    drive_next = '0;
    status_next.inputOk = inputGood; // see RULE_04
    anyOff = (mode_reg != MODE_CHARGING) || fault_reg ||
             sense_reg.cellAbsent || sense_reg.outputShort; // see RULE_08
    if (!anyOff) begin
      if (sense_reg.finishDetected && finishEnabled) begin
        status_next.statusB = 1'b1; // see RULE_07
      end else begin
        // Without termination only fast or precharge shows, see RULE_09
        status_next.statusA = 1'b1;
        status_next.statusB = !aboveLow; // see RULE_07
      end
      drive_next.powerSwitchOn = !(sense_reg.finishDetected && finishEnabled);
      drive_next.fastCurrentSel = aboveLow; // see RULE_10
    end
    drive_next.recoveryCurrentOn = fault_reg && sense_reg.inputPresent &&
                                   !aboveLow; // see RULE_16
  end

  // Registered state and outputs
  always_ff @(posedge sys_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      mode_reg <= MODE_STANDBY;
      count_reg <= '0;
      fault_reg <= 1'b0;
      statusOut <= '0;
      driveOut <= '0;
      prechargeFault <= 1'b0;
      modeOut <= MODE_STANDBY;
    end else begin
      mode_reg <= mode_next;
      count_reg <= count_next;
      fault_reg <= fault_next;
      statusOut <= status_next; // see RULE_21
      driveOut <= drive_next;
      prechargeFault <= fault_next;
      modeOut <= mode_next;
    end
  end
endmodule
`default_nettype wire

// ---- charge_ctrl_checker.sv ----
// Port-level assertions for the charge status and precharge timer block
`timescale 1ns/1ns
`default_nettype none
module charge_ctrl_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire charge_ctrl_pkg::sense_t senseIn,
  input wire charge_ctrl_pkg::status_t statusOut,
  input wire charge_ctrl_pkg::drive_t driveOut,
  input wire logic prechargeFault,
  input wire charge_ctrl_pkg::mode_t modeOut
);
  import charge_ctrl_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] upCnt_reg;
  logic [3:0] upCnt_next;
  logic up;
  logic okIn;
  logic tempOk;
  // ----------------------------------------
  // Settling counter after reset release
  // ----------------------------------------
  always_comb begin
    upCnt_next = (upCnt_reg == 4'hf) ? upCnt_reg : upCnt_reg + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) upCnt_reg <= 4'h0;
    else upCnt_reg <= upCnt_next;
  end
  // Synchroniser path is flushed once the counter passes eight
  assign up = upCnt_reg > 4'h8;
  assign okIn = senseIn.inputPresent & ~senseIn.inputOvervoltage;
  assign tempOk = senseIn.tempAboveCold & senseIn.tempBelowHot;
  a_fault_status_off:
    assert property (prechargeFault |=> !statusOut.statusA && !statusOut.statusB) else $error("status lit in fault");
  a_fault_switch_off:
    assert property (prechargeFault |=> !driveOut.powerSwitchOn) else $error("switch on in fault");
  a_recovery_cause:
    assert property (driveOut.recoveryCurrentOn |-> $past(prechargeFault)) else $error("recovery without fault");
  a_switch_needs_charge:
    assert property (driveOut.powerSwitchOn |-> $past(modeOut) == MODE_CHARGING) else $error("switch on outside charging");
  a_ok_follows_input:
    assert property ((up && okIn)[*5] |-> statusOut.inputOk) else $error("input ok not shown");
  a_ov_standby:
    assert property ((up && senseIn.inputOvervoltage)[*5] |-> modeOut == MODE_STANDBY) else $error("no standby on overvoltage");
  a_inhibit_standby:
    assert property ((up && senseIn.chargeInhibit)[*5] |-> modeOut == MODE_STANDBY) else $error("no standby on inhibit");
  a_temp_no_charge:
    assert property ((up && !tempOk)[*5] |-> modeOut != MODE_CHARGING) else $error("charging out of window");
endmodule
`default_nettype wire

// ---- status_pin_model.sv ----
// Indicator side of the open-collector status pins
`timescale 1ns/1ns
`default_nettype none
module status_pin_model (
  input wire charge_ctrl_pkg::status_t statusOut,
  output logic [2:0] pinLevel
);
  import charge_ctrl_pkg::*;
  // Pull-ups lift each pin while its transistor is off
  assign pinLevel = ~statusOut;
endmodule
`default_nettype wire

// ---- charge_status_and_precharge_timer_test.sv ----
// Self-checking bench for the charge status and precharge timer block
`timescale 1ns/1ns
`default_nettype none
module charge_status_and_precharge_timer_test;
  import charge_ctrl_pkg::*;
  localparam logic [8:0] ALL = 9'h1ff;
  localparam logic [8:0] NOFS = 9'h1f9;
  localparam logic [8:0] FLT = 9'h07b;
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic timerTick = 1'h0;
  logic [TICK_W-1:0] tmo = 24'h000002;
  logic [FACTOR_W-1:0] fac = 4'h1;
  sense_t s = '0;
  status_t statusOut;
  drive_t driveOut;
  logic prechargeFault;
  mode_t modeOut;
  logic [2:0] pinLevel;
  logic [8:0] noteQ[$];
  logic [8:0] maskQ[$];
  logic [8:0] m9;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int lim;
  event resultSeen;
  always #5 sys_clk = ~sys_clk;
  charge_status_and_precharge_timer i_dut (.sys_clk(sys_clk), .rstn(rstn), .senseIn(s),
    .timerTick(timerTick), .fastPhaseTimeout(tmo), .preconditionTimeFactor(fac),
    .statusOut(statusOut), .driveOut(driveOut), .prechargeFault(prechargeFault),
    .modeOut(modeOut));
  status_pin_model i_pins (.statusOut(statusOut), .pinLevel(pinLevel));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Notes an expectation, then lets the outputs settle before sampling
  task automatic note(input logic [8:0] e, input logic [8:0] m);
    noteQ.push_back(e & m);
    maskQ.push_back(m);
    repeat (8) @(negedge sys_clk);
    ->resultSeen;
    @(negedge sys_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      timerTick = 1'h1;
      @(negedge sys_clk);
      timerTick = 1'h0;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  // Compares each settled result against the oldest note
  always @(resultSeen) begin
    m9 = maskQ.pop_front();
    check({modeOut, statusOut, driveOut, prechargeFault} & m9, noteQ.pop_front());
  end
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    void'($urandom(72746));
    tmo = {21'h0, 3'($urandom_range(5, 2))};
    fac = 4'($urandom_range(3, 1));
    lim = int'(tmo) * int'(fac);
    repeat (20) @(negedge sys_clk);
    rstn = 1'h1;
    s = 11'h580; // Input present, temperature ok, below threshold
    note({MODE_CHARGING, 3'h7, 3'h4, 1'h0}, ALL);
    s.aboveLowVoltage = 1'h1;
    s.timerPinFloating = 1'h1;
    s.finishDetected = 1'h1;
    note({MODE_CHARGING, 3'h5, 3'h6, 1'h0}, ALL);
    s.tempBelowHot = 1'h0;
    note({MODE_SUSPEND, 3'h1, 3'h0, 1'h0}, NOFS);
    s.tempBelowHot = 1'h1;
    note({MODE_CHARGING, 3'h5, 3'h6, 1'h0}, ALL);
    s.inputOvervoltage = 1'h1;
    note({MODE_STANDBY, 3'h0, 3'h0, 1'h0}, NOFS);
    s.inputOvervoltage = 1'h0;
    note({MODE_CHARGING, 3'h5, 3'h6, 1'h0}, ALL);
    s = 11'h580;
    ticks(lim - 1);
    s.aboveLowVoltage = 1'h1;
    note({MODE_CHARGING, 3'h5, 3'h6, 1'h0}, ALL);
    s.aboveLowVoltage = 1'h0;
    ticks(lim - 1);
    s.tempAboveCold = 1'h0;
    note({MODE_SUSPEND, 3'h1, 3'h0, 1'h0}, NOFS);
    // Ticks while suspended must leave the held count alone
    ticks(3);
    s.tempAboveCold = 1'h1;
    note({MODE_CHARGING, 3'h7, 3'h4, 1'h0}, ALL);
    ticks(1);
    note({MODE_STANDBY, 3'h1, 3'h1, 1'h1}, FLT);
    s.chargeInhibit = 1'h1;
    note({MODE_STANDBY, 3'h1, 3'h0, 1'h0}, NOFS);
    s.chargeInhibit = 1'h0;
    note({MODE_CHARGING, 3'h7, 3'h4, 1'h0}, ALL);
    check({6'h0, pinLevel}, 9'h000);
    // Termination seen with the timer pin driven shows done, switch off
    s.finishDetected = 1'h1;
    note({MODE_CHARGING, 3'h3, 3'h0, 1'h0}, ALL);
    // A missing cell darkens both status pins
    s.cellAbsent = 1'h1;
    note({MODE_CHARGING, 3'h1, 3'h0, 1'h0}, ALL);
    close_out();
  end
endmodule
bind charge_status_and_precharge_timer charge_ctrl_checker i_chk (.sys_clk(sys_clk),
  .rstn(rstn), .senseIn(senseIn), .statusOut(statusOut), .driveOut(driveOut),
  .prechargeFault(prechargeFault), .modeOut(modeOut));
`default_nettype wire
